// [core/risc_pkg.sv]
package risc_pkg;

    // ============================================================
    // Register offsets (printed offsets are not all multiples of four)
    localparam logic [7:0] EDGE_RATE_IDX = 8'h31;
    localparam logic [7:0] INPUT_SEL_IDX = 8'h32;
    localparam int ADDR_LSB = 2;

    // ============================================================
    // Field positions
    localparam int PIN_B_EDGE_LSB = 2;
    localparam int PIN_A_EDGE_LSB = 0;
    localparam int SEC_BUF_LSB = 6;
    localparam int PRI_BUF_LSB = 4;
    localparam int PLL_B_REF_LSB = 2;
    localparam int PLL_A_REF_LSB = 0;

    // ============================================================
    // Reset values
    localparam logic [1:0] PIN_B_EDGE_RST = 2'h0;
    localparam logic [1:0] PIN_A_EDGE_RST = 2'h0;
    localparam logic [1:0] SEC_BUF_RST = 2'h2;
    localparam logic [1:0] PRI_BUF_RST = 2'h1;
    localparam logic [1:0] PLL_B_REF_RST = 2'h1;
    localparam logic [1:0] PLL_A_REF_RST = 2'h1;

    // ============================================================
    // Codes
    localparam logic [1:0] EDGE_FAST = 2'h0;
    localparam logic [1:0] EDGE_SLOW = 2'h2;
    localparam logic [1:0] BUF_SINGLE = 2'h0;
    localparam logic [1:0] BUF_DIFF = 2'h1;
    localparam logic [1:0] BUF_XTAL = 2'h2;
    localparam logic [1:0] BUF_OFF = 2'h3;
    localparam logic [1:0] REF_AUTO = 2'h0;
    localparam logic [1:0] REF_PIN = 2'h1;
    localparam logic [1:0] REF_PRI = 2'h2;
    localparam logic [1:0] REF_SEC = 2'h3;

    // Three-level select pin
    typedef enum logic [2:0] {
        RISC_PIN_LOW = 3'b001,
        RISC_PIN_MID = 3'b010,
        RISC_PIN_HIGH = 3'b100
    } risc_pin_lvl_t;

    // Mux selection state, one-hot
    typedef enum logic [1:0] {
        RISC_SEL_PRI = 2'b01,
        RISC_SEL_SEC = 2'b10
    } risc_sel_t;

    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

endpackage : risc_pkg

// [core/risc_ref_mux.sv]
`timescale 1ns/1ps
`default_nettype none
module risc_ref_mux (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [1:0] i_choice,
    input wire logic [2:0] i_pin_lvl,
    input wire logic i_pin_low_pri,
    input wire logic i_pin_mid_auto,
    input wire logic i_pri_ok,
    output logic o_use_sec
);

    // ============================================================
    // Mode decode
    logic pin_auto;
    logic pin_pick_sec;
    logic auto_mode;
    logic force_sec;
    risc_pkg::risc_sel_t sel_r;
    risc_pkg::risc_sel_t sel_nxt;

    // Pin low picks a fixed input; mid follows the per-PLL decode
    assign pin_auto = (i_pin_lvl == risc_pkg::RISC_PIN_HIGH)
        || ((i_pin_lvl == risc_pkg::RISC_PIN_MID) && i_pin_mid_auto);
    assign pin_pick_sec = !pin_auto && !i_pin_low_pri;
    assign auto_mode = (i_choice == risc_pkg::REF_AUTO)
        || ((i_choice == risc_pkg::REF_PIN) && pin_auto);
    assign force_sec = (i_choice == risc_pkg::REF_SEC)
        || ((i_choice == risc_pkg::REF_PIN) && pin_pick_sec);

    // Auto: primary while valid, secondary otherwise, back when it recovers
    always_comb begin
        sel_nxt = risc_pkg::RISC_SEL_PRI;
        if (auto_mode) begin
            sel_nxt = i_pri_ok ? risc_pkg::RISC_SEL_PRI : risc_pkg::RISC_SEL_SEC;
        end else if (force_sec) begin
            sel_nxt = risc_pkg::RISC_SEL_SEC;
        end
    end

    // Registered so the mux select never glitches
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sel_r <= risc_pkg::RISC_SEL_PRI;
        end else begin
            sel_r <= sel_nxt;
        end
    end

    always_comb begin
        case (sel_r)
            risc_pkg::RISC_SEL_PRI: o_use_sec = 1'b0;
            risc_pkg::RISC_SEL_SEC: o_use_sec = 1'b1;
            default: o_use_sec = 1'b0;
        endcase
    end

endmodule : risc_ref_mux
`default_nettype wire

// [core/risc_top.sv]
// Behaviour
// - Pin B edge rate at bits 3:2, reset 0; 0 fast, 2 slow.
// - Pin A edge rate at bits 1:0, reset 0; 0 fast, 2 slow.
// - Secondary buffer mode bits 7:6, reset 2: single, diff, crystal, off.
// - Primary buffer mode bits 5:4, reset 1: single, diff, off, off.
// - PLL B reference choice bits 3:2, reset 1: auto, pin, primary, secondary.
// - PLL B pin mode: low or mid picks secondary, high gives automatic.
// - PLL A reference choice bits 1:0, reset 1, same coding as PLL B.
// - PLL A pin mode: low picks primary, mid or high gives automatic.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module risc_top (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [31:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [31:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic [2:0] i_reference_select_pin,
    input wire logic i_pri_valid,
    output logic [1:0] o_status_pin_b_edge_rate,
    output logic [1:0] o_status_pin_a_edge_rate,
    output logic [1:0] o_secondary_buffer_mode,
    output logic [1:0] o_primary_buffer_mode,
    output logic o_pll_a_use_sec,
    output logic o_pll_b_use_sec
);

    // ============================================================
    // Register state
    logic [1:0] pin_b_edge_r;
    logic [1:0] pin_a_edge_r;
    logic [1:0] sec_buf_r;
    logic [1:0] pri_buf_r;
    logic [1:0] pll_b_ref_r;
    logic [1:0] pll_a_ref_r;
    logic aw_held_r;
    logic w_held_r;
    logic [31:0] awaddr_r;
    logic [7:0] wbyte_r;
    logic wstrb0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // ============================================================
    // Write channel: address and data taken in either order
    logic aw_take;
    logic w_take;
    logic wr_go;
    logic [31:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane0;
    logic wr_edge;
    logic wr_sel;
    logic wr_hit;
    logic wr_en_edge;
    logic wr_en_sel;
    logic aw_held_nxt;
    logic w_held_nxt;
    logic bvalid_nxt;

    // Take only while the registered ready is shown, so master and slave agree
    assign aw_take = i_awvalid && o_awready;
    assign w_take = i_wvalid && o_wready;
    assign wr_go = (aw_held_r || aw_take) && (w_held_r || w_take) && !bvalid_r;
    assign wr_addr = aw_held_r ? awaddr_r : i_awaddr;
    assign wr_byte = w_held_r ? wbyte_r : i_wdata[7:0];
    assign wr_lane0 = w_held_r ? wstrb0_r : i_wstrb[0];
    assign wr_edge = (wr_addr == {22'h0, risc_pkg::EDGE_RATE_IDX, 2'h0});
    assign wr_sel = (wr_addr == {22'h0, risc_pkg::INPUT_SEL_IDX, 2'h0});
    assign wr_hit = wr_edge || wr_sel;
    assign wr_en_edge = wr_go && wr_edge && wr_lane0;
    assign wr_en_sel = wr_go && wr_sel && wr_lane0;
    assign aw_held_nxt = (aw_held_r || aw_take) && !wr_go;
    assign w_held_nxt = (w_held_r || w_take) && !wr_go;
    assign bvalid_nxt = wr_go || (bvalid_r && !i_bready);

    // Hold halves until the partner arrives
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 32'h0;
            wbyte_r <= 8'h0;
            wstrb0_r <= 1'b0;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            if (aw_take) begin
                awaddr_r <= i_awaddr;
            end
            if (w_take) begin
                wbyte_r <= i_wdata[7:0];
                wstrb0_r <= i_wstrb[0];
            end
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            bvalid_r <= 1'b0;
            bresp_r <= risc_pkg::AXI_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? risc_pkg::AXI_OKAY : risc_pkg::AXI_SLVERR;
        end else if (i_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ============================================================
    // Configuration fields; upper bits of the edge register are dropped
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pin_b_edge_r <= risc_pkg::PIN_B_EDGE_RST;
            pin_a_edge_r <= risc_pkg::PIN_A_EDGE_RST;
        end else if (wr_en_edge) begin
            pin_b_edge_r <= wr_byte[risc_pkg::PIN_B_EDGE_LSB +: 2];
            pin_a_edge_r <= wr_byte[risc_pkg::PIN_A_EDGE_LSB +: 2];
        end
    end

    // Input selection fields, whole byte is defined
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sec_buf_r <= risc_pkg::SEC_BUF_RST;
            pri_buf_r <= risc_pkg::PRI_BUF_RST;
            pll_b_ref_r <= risc_pkg::PLL_B_REF_RST;
            pll_a_ref_r <= risc_pkg::PLL_A_REF_RST;
        end else if (wr_en_sel) begin
            sec_buf_r <= wr_byte[risc_pkg::SEC_BUF_LSB +: 2];
            pri_buf_r <= wr_byte[risc_pkg::PRI_BUF_LSB +: 2];
            pll_b_ref_r <= wr_byte[risc_pkg::PLL_B_REF_LSB +: 2];
            pll_a_ref_r <= wr_byte[risc_pkg::PLL_A_REF_LSB +: 2];
        end
    end

    // ============================================================
    // Read channel
    logic ar_take;
    logic rd_edge;
    logic rd_sel;
    logic [31:0] rd_edge_word;
    logic [31:0] rd_sel_word;
    logic rvalid_nxt;

    assign ar_take = i_arvalid && o_arready;
    assign rvalid_nxt = ar_take || (rvalid_r && !i_rready);
    assign rd_edge = (i_araddr == {22'h0, risc_pkg::EDGE_RATE_IDX, 2'h0});
    assign rd_sel = (i_araddr == {22'h0, risc_pkg::INPUT_SEL_IDX, 2'h0});
    // Reserved bits 7:4 and upper lanes read zero
    assign rd_edge_word = {28'h0, pin_b_edge_r, pin_a_edge_r};
    assign rd_sel_word = {24'h0, sec_buf_r, pri_buf_r, pll_b_ref_r, pll_a_ref_r};

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= risc_pkg::AXI_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_edge ? rd_edge_word : (rd_sel ? rd_sel_word : 32'h0);
            rresp_r <= (rd_edge || rd_sel) ? risc_pkg::AXI_OKAY : risc_pkg::AXI_SLVERR;
        end else if (i_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Ready lines are flops: high while a channel may accept
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_arready <= 1'b0;
        end else begin
            o_awready <= !aw_held_nxt && !bvalid_nxt;
            o_wready <= !w_held_nxt && !bvalid_nxt;
            o_arready <= !rvalid_nxt;
        end
    end

    // ============================================================
    // Reference muxes; PLL A low pin means primary, PLL B mid means secondary
    logic pll_a_sec;
    logic pll_b_sec;

    risc_ref_mux u_mux_a (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_choice(pll_a_ref_r),
        .i_pin_lvl(i_reference_select_pin),
        .i_pin_low_pri(1'b1),
        .i_pin_mid_auto(1'b1),
        .i_pri_ok(i_pri_valid),
        .o_use_sec(pll_a_sec)
    );

    risc_ref_mux u_mux_b (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_choice(pll_b_ref_r),
        .i_pin_lvl(i_reference_select_pin),
        .i_pin_low_pri(1'b0),
        .i_pin_mid_auto(1'b0),
        .i_pri_ok(i_pri_valid),
        .o_use_sec(pll_b_sec)
    );

    // Outputs straight from flops
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_pll_a_use_sec <= 1'b0;
            o_pll_b_use_sec <= 1'b0;
        end else begin
            o_pll_a_use_sec <= pll_a_sec;
            o_pll_b_use_sec <= pll_b_sec;
        end
    end

    assign o_status_pin_b_edge_rate = pin_b_edge_r;
    assign o_status_pin_a_edge_rate = pin_a_edge_r;
    assign o_secondary_buffer_mode = sec_buf_r;
    assign o_primary_buffer_mode = pri_buf_r;
    assign o_bvalid = bvalid_r;
    assign o_bresp = bresp_r;
    assign o_rvalid = rvalid_r;
    assign o_rdata = rdata_r;
    assign o_rresp = rresp_r;

    // ============================================================
    // Checks
    logic past_ok_r;
    always_ff @(posedge i_core_clk) begin
        past_ok_r <= !i_sys_rst;
    end

    a_reset_edge: assert property (@(posedge i_core_clk)
        $fell(i_sys_rst) |-> (pin_b_edge_r == 2'h0 && pin_a_edge_r == 2'h0))
        else $error("edge rate fields not zero after reset");
    a_reset_sel: assert property (@(posedge i_core_clk)
        $fell(i_sys_rst) |-> (rd_sel_word[7:0] == 8'h95))
        else $error("input select reset value wrong");
    a_write_edge: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        wr_en_edge |=> (pin_a_edge_r == $past(wr_byte[1:0])))
        else $error("pin A edge write lost");
    a_write_pllb: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        wr_en_sel |=> (pll_b_ref_r == $past(wr_byte[3:2]) && pri_buf_r == $past(wr_byte[5:4])))
        else $error("select field write lost");
    a_pin_b_sec: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || !past_ok_r)
        (pll_b_ref_r == 2'h1 && i_reference_select_pin != 3'b100) [*2] |=> o_pll_b_use_sec)
        else $error("PLL B pin low or mid must pick secondary");
    a_pin_a_pri: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || !past_ok_r)
        (pll_a_ref_r == 2'h1 && i_reference_select_pin == 3'b001) [*2] |=> !o_pll_a_use_sec)
        else $error("PLL A pin low must pick primary");
    a_auto_fall: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || !past_ok_r)
        (pll_a_ref_r == 2'h0 && !i_pri_valid) [*2] |=> o_pll_a_use_sec)
        else $error("auto mode did not fall back to secondary");
    a_force_sec: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || !past_ok_r)
        (pll_a_ref_r == 2'h3) [*2] |=> o_pll_a_use_sec)
        else $error("forced secondary not applied");
    a_resv_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (rvalid_r && $rose(rvalid_r)) |-> (rdata_r[31:8] == 24'h0))
        else $error("reserved read bits not zero");
    a_force_pri: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || !past_ok_r)
        (pll_b_ref_r == 2'h2) [*2] |=> !o_pll_b_use_sec)
        else $error("PLL B forced primary not applied");
    a_pin_b_auto: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || !past_ok_r)
        (pll_b_ref_r == 2'h1 && i_reference_select_pin == 3'b100 && i_pri_valid) [*2]
        |=> !o_pll_b_use_sec)
        else $error("PLL B pin high must run automatic");
    a_pin_a_auto: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || !past_ok_r)
        (pll_a_ref_r == 2'h1 && i_reference_select_pin == 3'b010 && !i_pri_valid) [*2]
        |=> o_pll_a_use_sec)
        else $error("PLL A pin mid must run automatic");
    a_auto_back: assert property (@(posedge i_core_clk) disable iff (i_sys_rst || !past_ok_r)
        (pll_a_ref_r == 2'h0 && i_pri_valid) [*2] |=> !o_pll_a_use_sec)
        else $error("auto mode did not return to primary");
    a_edge_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !wr_en_edge |=> ($stable(pin_b_edge_r) && $stable(pin_a_edge_r)))
        else $error("edge rate fields changed without a write");

    c_write_sel: cover property (@(posedge i_core_clk) wr_en_sel);
    c_read_edge: cover property (@(posedge i_core_clk) ar_take && rd_edge);
    c_auto_back: cover property (@(posedge i_core_clk) o_pll_a_use_sec ##1 !o_pll_a_use_sec);
    c_bad_addr: cover property (@(posedge i_core_clk) wr_go && !wr_hit);

endmodule : risc_top
`default_nettype wire

// [testbench/ref_input_select_config_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ref_input_select_config_tb;
    // ============================================================
    // Design ports and bench state
    logic i_core_clk, i_sys_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [31:0] i_awaddr, i_wdata, i_araddr;
    logic [3:0] i_wstrb;
    logic [2:0] i_reference_select_pin;
    logic i_pri_valid;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_pll_a_use_sec, o_pll_b_use_sec;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata;
    logic [1:0] o_status_pin_b_edge_rate, o_status_pin_a_edge_rate;
    logic [1:0] o_secondary_buffer_mode, o_primary_buffer_mode;
    logic [1:0] exp_b[$];
    logic [1:0] exp_rr[$];
    logic [31:0] exp_rd[$];
    logic [1:0] mon_resp;
    logic [31:0] mon_data;
    logic [31:0] d;
    logic [1:0] ea, eb;
    logic [2:0] lv [3] = '{risc_pkg::RISC_PIN_LOW, risc_pkg::RISC_PIN_MID, risc_pkg::RISC_PIN_HIGH};
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    integer seed;
    // Byte address is four times the printed index
    localparam logic [31:0] EDGE_ADDR = {22'h0, risc_pkg::EDGE_RATE_IDX, 2'b00};
    localparam logic [31:0] SEL_ADDR = {22'h0, risc_pkg::INPUT_SEL_IDX, 2'b00};

    risc_top uut (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_awaddr(i_awaddr),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
        .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
        .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
        .i_rready(i_rready), .i_reference_select_pin(i_reference_select_pin),
        .i_pri_valid(i_pri_valid), .o_status_pin_b_edge_rate(o_status_pin_b_edge_rate),
        .o_status_pin_a_edge_rate(o_status_pin_a_edge_rate),
        .o_secondary_buffer_mode(o_secondary_buffer_mode),
        .o_primary_buffer_mode(o_primary_buffer_mode),
        .o_pll_a_use_sec(o_pll_a_use_sec), .o_pll_b_use_sec(o_pll_b_use_sec));

    // ============================================================
    // Compare and report
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        cmp_word({30'h0, got}, {30'h0, exp});
    endtask : cmp_resp

    task automatic cmp_sel(input logic [1:0] got, input logic [1:0] exp);
        cmp_word({30'h0, got}, {30'h0, exp});
    endtask : cmp_sel

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // ============================================================
    // Bus master; ready is never assumed, only the timeout ends a wait
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] dat, input logic [3:0] s,
                          input logic [1:0] er);
        logic aw_p, w_p, b_p;
        exp_b.push_back(er);
        aw_p = 1'b1;
        w_p = 1'b1;
        b_p = 1'b1;
        i_awaddr <= a;
        i_awvalid <= 1'b1;
        i_wdata <= dat;
        i_wstrb <= s;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        // Each channel is released only at its own handshake edge
        while (b_p) begin
            @(posedge i_core_clk);
            if (aw_p && o_awready) begin
                i_awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_p && o_wready) begin
                i_wvalid <= 1'b0;
                w_p = 1'b0;
            end
            if (b_p && o_bvalid) begin
                i_bready <= 1'b0;
                b_p = 1'b0;
            end
        end
        // Idle edge so a following call never rewrites a signal in this step
        @(posedge i_core_clk);
    endtask : axi_wr

    task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_p, r_p;
        exp_rr.push_back(er);
        exp_rd.push_back(ed);
        ar_p = 1'b1;
        r_p = 1'b1;
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        while (r_p) begin
            @(posedge i_core_clk);
            if (ar_p && o_arready) begin
                i_arvalid <= 1'b0;
                ar_p = 1'b0;
            end
            if (r_p && o_rvalid) begin
                i_rready <= 1'b0;
                r_p = 1'b0;
            end
        end
        @(posedge i_core_clk);
    endtask : axi_rd

    // Reference choice expected from the select codes and the pin level
    function automatic logic exp_sec(input logic [1:0] ch, input logic [2:0] pin,
                                     input logic pv, input logic b);
        logic auto_m;
        auto_m = (ch == risc_pkg::REF_AUTO) || (ch == risc_pkg::REF_PIN &&
                 (b ? pin == risc_pkg::RISC_PIN_HIGH : pin != risc_pkg::RISC_PIN_LOW));
        if (auto_m) return !pv;
        if (ch == risc_pkg::REF_PIN) return b;
        return ch == risc_pkg::REF_SEC;
    endfunction : exp_sec

    // ============================================================
    // Clock, timeout and response monitor
    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end

    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    // Oldest note is taken whenever a response is handed over
    always @(posedge i_core_clk) begin
        if (o_bvalid && i_bready) cmp_resp(o_bresp, exp_b.pop_front());
        if (o_rvalid && i_rready) begin
            mon_resp = exp_rr.pop_front();
            mon_data = exp_rd.pop_front();
            cmp_resp(o_rresp, mon_resp);
            if (mon_resp === risc_pkg::AXI_OKAY) cmp_word(o_rdata, mon_data);
        end
    end

    // ============================================================
    // Main sequence
    initial begin
        seed = 10649;
        i_sys_rst = 1'b1;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h0;
        {i_awaddr, i_wdata, i_araddr} = 96'h0;
        i_wstrb = 4'h0;
        i_reference_select_pin = risc_pkg::RISC_PIN_LOW;
        i_pri_valid = 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        cmp_sel(o_status_pin_b_edge_rate, risc_pkg::PIN_B_EDGE_RST);
        cmp_sel(o_status_pin_a_edge_rate, risc_pkg::PIN_A_EDGE_RST);
        cmp_sel(o_secondary_buffer_mode, risc_pkg::SEC_BUF_RST);
        cmp_sel(o_primary_buffer_mode, risc_pkg::PRI_BUF_RST);
        cmp_sel({1'b0, o_pll_a_use_sec}, 2'h0);
        cmp_sel({1'b0, o_pll_b_use_sec}, 2'h1);
        axi_rd(EDGE_ADDR, 32'h0, risc_pkg::AXI_OKAY);
        axi_rd(SEL_ADDR, 32'h95, risc_pkg::AXI_OKAY);
        // Both edge codes on both pins, junk in the reserved bits
        for (int k = 0; k < 4; k++) begin
            ea = k[0] ? risc_pkg::EDGE_SLOW : risc_pkg::EDGE_FAST;
            eb = k[1] ? risc_pkg::EDGE_SLOW : risc_pkg::EDGE_FAST;
            d = $random(seed);
            axi_wr(EDGE_ADDR, {d[31:4], eb, ea}, 4'hf, risc_pkg::AXI_OKAY);
            axi_rd(EDGE_ADDR, {28'h0, eb, ea}, risc_pkg::AXI_OKAY);
            cmp_sel(o_status_pin_b_edge_rate, eb);
            cmp_sel(o_status_pin_a_edge_rate, ea);
        end
        // Strobe-less and unmapped accesses must leave the stored fields alone
        axi_wr(EDGE_ADDR, 32'h0, 4'h0, risc_pkg::AXI_OKAY);
        axi_wr(32'hcc, 32'hff, 4'hf, risc_pkg::AXI_SLVERR);
        axi_rd(32'hcc, 32'h0, risc_pkg::AXI_SLVERR);
        axi_rd(EDGE_ADDR, 32'ha, risc_pkg::AXI_OKAY);
        // Every choice pair, every pin level, primary lost and recovered
        for (int c = 0; c < 16; c++) begin
            d = $random(seed);
            d[3:0] = c[3:0];
            axi_wr(SEL_ADDR, d, 4'hf, risc_pkg::AXI_OKAY);
            axi_rd(SEL_ADDR, {24'h0, d[7:0]}, risc_pkg::AXI_OKAY);
            cmp_sel(o_secondary_buffer_mode, d[7:6]);
            cmp_sel(o_primary_buffer_mode, d[5:4]);
            for (int p = 0; p < 6; p++) begin
                i_reference_select_pin <= lv[p % 3];
                i_pri_valid <= (p >= 3);
                repeat (3) @(posedge i_core_clk);
                cmp_sel({1'b0, o_pll_a_use_sec}, {1'b0, exp_sec(d[1:0], lv[p % 3], p >= 3, 1'b0)});
                cmp_sel({1'b0, o_pll_b_use_sec}, {1'b0, exp_sec(d[3:2], lv[p % 3], p >= 3, 1'b1)});
            end
        end
        repeat (2) @(posedge i_core_clk);
        print_verdict();
    end
endmodule : ref_input_select_config_tb
`default_nettype wire
